// file: verilog/ias_cfg.svh
// constants for the interrupt acceptance sequencer
`ifndef IAS_CFG_SVH
`define IAS_CFG_SVH
// register byte offsets on the avalon slave
`define IAS_OFF_ENABLE 4'h0
`define IAS_OFF_PEND   4'h4
`define IAS_OFF_CTRL   4'h8
`define IAS_OFF_STAT   4'hC
// field positions
`define IAS_MEF_BIT      0
`define IAS_STK_MEF_BIT  0
`define IAS_CTRL_RST_BIT 0
`define IAS_CTRL_SC_BIT  1
`define IAS_STAT_NM_BIT  4
`define IAS_STAT_BSY_BIT 5
// reset values
`define IAS_ENABLE_RESET 16'h0000
`define IAS_PEND_RESET   16'h0000
`define IAS_CTRL_RESET   2'h2
// source numbers, lower number wins
`define IAS_SRC_SW    4'h1
`define IAS_SRC_UNDEF 4'h2
`define IAS_SRC_FAULT 4'h3
`define IAS_FIRST_MASK 4
// opcode returned for a missing address
`define IAS_SWI_OPCODE 8'hFF
// memory layout
`define IAS_VEC_BASE 16'hFFE0
`define IAS_DATA_TOP 16'h03FF
`define IAS_ROM_BOT  16'hC000
// acceptance sequence cycles, eight in all
`define IAS_ACC_PSW  3'h0
`define IAS_ACC_PCH  3'h1
`define IAS_ACC_PCL  3'h2
`define IAS_ACC_VLO  3'h3
`define IAS_ACC_VHI  3'h4
`define IAS_ACC_GLO  3'h5
`define IAS_ACC_GHI  3'h6
`define IAS_ACC_LAST 3'h7
// return sequence cycles
`define IAS_RET_RLO  3'h0
`define IAS_RET_RHI  3'h1
`define IAS_RET_GLO  3'h2
`define IAS_RET_GHI  3'h3
`define IAS_RET_LAST 3'h4
`define IAS_ONE_CYC  3'h1
`define IAS_SP_STEP  16'h0003
`endif

// file: verilog/ias_pkg.sv
// types shared by the interrupt acceptance sequencer
package ias_pkg;
  // sequencer states
  typedef enum logic [1:0] {
    IAS_IDLE,
    IAS_ACC,
    IAS_RET
  } ias_state_type;
endpackage

// file: verilog/ias_sequencer.sv
// interrupt acceptance and return sequencer with avalon register slave
// Functional notes
// - pending latch holds until accepted or cleared
// - acceptance takes eight cycles after instruction
// - acceptance clears the master enable
// - acceptance clears the accepted pending latch
// - push status, pc high, pc low; sp-3
// - load pc from the source vector slot
// - acceptance starts within 38 clocks
// - master enable low blocks all maskable
// - only pc and status word saved
// - two return kinds end their service
// - return pops pc and status; sp+3
// - pc low at sp+1, high sp+2
// - sample requests in last instruction cycle
// - trap opcode starts software interrupt, top priority
// - missing address fetch returns trap opcode
// - fetch from data areas raises fetch fault
// - bad opcode accepted at once, breaks processing
// - fetch fault accepted at once, even nested
// - control bit selects reset or interrupt
// - master enable is bit zero, resets low
// - non-maskable ignore all enable flags
//
// Added by the designer: the address map and the Avalon-MM slave port.
`timescale 1ns/1ns
`include "ias_cfg.svh"

module ias_sequencer (
  input  wire logic        clk,
  input  wire logic        rst,
  // avalon-mm slave
  input  wire logic [3:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  input  wire logic [3:0]  avs_byteenable,
  output logic      [31:0] avs_readdata,
  output logic             avs_waitrequest,
  // cpu instruction sequencer
  input  wire logic        insn_last,
  input  wire logic [15:0] pc_in,
  input  wire logic [6:0]  psw_in,
  input  wire logic [15:0] sp_in,
  input  wire logic        bad_opcode,
  input  wire logic        return_maskable,
  input  wire logic        return_nonmaskable,
  input  wire logic        fetch_valid,
  input  wire logic [15:0] fetch_addr,
  input  wire logic [7:0]  fetch_data,
  output logic      [7:0]  opcode_out,
  output logic             opcode_valid,
  output logic             cpu_hold,
  output logic             pc_load,
  output logic      [15:0] pc_value,
  output logic             psw_load,
  output logic      [6:0]  psw_value,
  output logic             sp_load,
  output logic      [15:0] sp_value,
  output logic             trap_reset,
  // stack and vector memory
  output logic             mem_wr,
  output logic             mem_rd,
  output logic      [15:0] mem_addr,
  output logic      [7:0]  mem_wdata,
  input  wire logic [7:0]  mem_rdata,
  // peripheral request pulses
  input  wire logic [15:4] irq_req
);

  // sequencer state and step counter
  ias_pkg::ias_state_type state_reg;
  logic [2:0]  cyc_reg;
  // software visible state
  logic [15:0] enable_reg;   // source enables, master at bit 0
  logic [15:0] pend_reg;     // pending request latches
  logic [1:0]  ctrl_reg;     // trap reset mode, single chip
  logic        nm_act_reg;   // non-maskable service in progress
  // context captured at acceptance
  logic [3:0]  src_reg;
  logic [15:0] spw_reg;      // stack pointer at sequence start
  logic [15:0] pcs_reg;      // pc to save, or pc being restored
  logic [6:0]  psws_reg;
  logic        mefs_reg;     // master enable to save
  logic [7:0]  lo_reg;       // low byte gathered from memory
  // bus handshake
  logic        ack_reg;

  // bus decode
  wire bus_req  = avs_read | avs_write;
  wire bus_wr   = avs_write & ack_reg;
  wire sel_en   = avs_address == `IAS_OFF_ENABLE;
  wire sel_pend = avs_address == `IAS_OFF_PEND;
  wire sel_ctrl = avs_address == `IAS_OFF_CTRL;
  wire sel_stat = avs_address == `IAS_OFF_STAT;
  // lane mask for the low halfword
  wire [15:0] lane = {{8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};

  // read mux; unmapped offsets read zero
  wire [31:0] rd_mux =
    sel_en   ? {16'h0000, enable_reg} :
    sel_pend ? {16'h0000, pend_reg} :
    sel_ctrl ? {30'h00000000, ctrl_reg} :
    sel_stat ? {26'h0000000, state_reg != ias_pkg::IAS_IDLE,
                nm_act_reg, src_reg} :
               32'h00000000;

  // fetch checks
  wire in_data  = fetch_addr <= `IAS_DATA_TOP;
  wire missing  = ctrl_reg[`IAS_CTRL_SC_BIT] & ~in_data &
                  (fetch_addr < `IAS_ROM_BOT);
  wire [7:0] eff_op = missing ? `IAS_SWI_OPCODE : fetch_data;
  wire fault    = fetch_valid & in_data;
  wire sw_req   = fetch_valid & ~in_data & (eff_op == `IAS_SWI_OPCODE);
  // control bit picks reset or interrupt
  wire fault_irq = fault & ~ctrl_reg[`IAS_CTRL_RST_BIT];
  wire fault_rst = fault & ctrl_reg[`IAS_CTRL_RST_BIT];

  // set vector, source 0 is unused
  wire [15:0] set_vec = {irq_req, fault_irq, bad_opcode, sw_req, 1'b0};

  // source selection
  logic [15:0] elig;
  logic [3:0]  pick;
  logic        any_mask;
  logic        any_now;
  // walk down from the highest number so the lowest, top priority, is picked last and wins
  always_comb begin
    elig     = 16'h0000;
    pick     = 4'h0;
    any_mask = 1'b0;
    any_now  = 1'b0;
    for (int i = 15; i >= 1; i--) begin
      if (i < `IAS_FIRST_MASK) begin
        elig[i] = pend_reg[i];
        if (pend_reg[i]) begin
          any_now = 1'b1;
        end
      end else begin
        elig[i] = pend_reg[i] & enable_reg[i] &
                  enable_reg[`IAS_MEF_BIT];
        if (elig[i]) begin
          any_mask = 1'b1;
        end
      end
      if (elig[i]) begin
        pick = 4'(i);
      end
    end
  end

  wire idle = state_reg == ias_pkg::IAS_IDLE;
  wire ret_end = (state_reg == ias_pkg::IAS_RET) &
                 (cyc_reg == `IAS_RET_LAST);
  // boundary sampling bounds the start delay
  // sample maskable at last instruction cycle or return end, non-maskable in any idle cycle
  wire accept = (idle & (any_now | (insn_last & any_mask))) |
                (ret_end & (any_now | any_mask));
  // either return kind starts the pop sequence
  wire ret_go = idle & ~accept & (return_maskable | return_nonmaskable);

  // restored values at the end of a return
  // gathered word: byte now on the bus over the kept low byte
  wire [15:0] pc_rest  = {mem_rdata, lo_reg};
  wire [15:0] sp_rest  = spw_reg + `IAS_SP_STEP;
  // the popped status byte stands on the bus in the last cycle
  wire        mef_rest = mem_rdata[`IAS_STK_MEF_BIT];
  // context source: live cpu values, or restored ones after a return
  wire [15:0] pc_cap  = ret_end ? pcs_reg : pc_in;
  wire [15:0] sp_cap  = ret_end ? sp_rest : sp_in;

  // pending latches
  wire [15:0] clr_bus = (bus_wr & sel_pend) ?
                        (lane & ~avs_writedata[15:0]) : 16'h0000;
  logic [15:0] pend_next;
  genvar g;
  generate
    for (g = 0; g < 16; g++) begin : g_pend
      // hold until accepted or cleared; set wins
      assign pend_next[g] = set_vec[g] |
        (pend_reg[g] & ~clr_bus[g] &
         ~(accept & (pick == 4'(g))));
    end
  endgenerate

  // latch update
  always_ff @(posedge clk) begin
    if (rst) begin
      pend_reg <= `IAS_PEND_RESET;
    end else begin
      pend_reg <= pend_next;
    end
  end

  // bus slave
  // waitrequest drops for one cycle, the second of the request
  always_ff @(posedge clk) begin
    if (rst) begin
      ack_reg         <= 1'b0;
      avs_waitrequest <= 1'b1;
      avs_readdata    <= 32'h00000000;
    end else begin
      ack_reg         <= bus_req & ~ack_reg;
      avs_waitrequest <= ~(bus_req & ~ack_reg);
      avs_readdata    <= rd_mux;
    end
  end

  // control register
  always_ff @(posedge clk) begin
    if (rst) begin
      ctrl_reg <= `IAS_CTRL_RESET;
    end else if (bus_wr & sel_ctrl & avs_byteenable[0]) begin
      ctrl_reg <= avs_writedata[1:0];
    end
  end

  // enables; hardware actions come after the bus write
  always_ff @(posedge clk) begin
    if (rst) begin
      enable_reg <= `IAS_ENABLE_RESET;
    end else begin
      if (bus_wr & sel_en) begin
        enable_reg <= (enable_reg & ~lane) |
                      (avs_writedata[15:0] & lane);
      end
      if (ret_end) begin
        enable_reg[`IAS_MEF_BIT] <= mef_rest;
      end
      if (accept) begin
        enable_reg[`IAS_MEF_BIT] <= 1'b0;
      end
    end
  end

  // sequencer
  // state and step counter
  always_ff @(posedge clk) begin
    if (rst) begin
      state_reg <= ias_pkg::IAS_IDLE;
      cyc_reg   <= 3'h0;
    end else if (accept) begin
      state_reg <= ias_pkg::IAS_ACC;
      cyc_reg   <= 3'h0;
    end else if (ret_go) begin
      state_reg <= ias_pkg::IAS_RET;
      cyc_reg   <= 3'h0;
    end else if ((state_reg == ias_pkg::IAS_ACC &&
                  cyc_reg == `IAS_ACC_LAST) || ret_end) begin
      state_reg <= ias_pkg::IAS_IDLE;
      cyc_reg   <= 3'h0;
    end else if (!idle) begin
      cyc_reg <= cyc_reg + `IAS_ONE_CYC;
    end
  end

  // context capture and gathered bytes
  always_ff @(posedge clk) begin
    if (rst) begin
      src_reg  <= 4'h0;
      spw_reg  <= 16'h0000;
      pcs_reg  <= 16'h0000;
      psws_reg <= 7'h00;
      mefs_reg <= 1'b0;
      lo_reg   <= 8'h00;
    end else if (accept) begin
      // only pc and status word are kept
      src_reg  <= pick;
      spw_reg  <= sp_cap;
      pcs_reg  <= pc_cap;
      psws_reg <= ret_end ? mem_rdata[7:1] : psw_in;
      mefs_reg <= ret_end ? mef_rest : enable_reg[`IAS_MEF_BIT];
    end else if (ret_go) begin
      spw_reg <= sp_in;
    end else if (state_reg == ias_pkg::IAS_ACC &&
                 cyc_reg == `IAS_ACC_GLO) begin
      lo_reg <= mem_rdata;
    end else if (state_reg == ias_pkg::IAS_ACC &&
                 cyc_reg == `IAS_ACC_GHI) begin
      // the high byte stands only this cycle, so keep the entry here
      pcs_reg <= pc_rest;
    end else if (state_reg == ias_pkg::IAS_RET) begin
      case (cyc_reg)
        `IAS_RET_GLO: lo_reg <= mem_rdata;
        `IAS_RET_GHI: pcs_reg <= pc_rest;
        default: ;
      endcase
    end
  end

  // memory port, one read latency cycle
  always_ff @(posedge clk) begin
    if (rst) begin
      mem_wr    <= 1'b0;
      mem_rd    <= 1'b0;
      mem_addr  <= 16'h0000;
      mem_wdata <= 8'h00;
    end else begin
      mem_wr <= 1'b0;
      mem_rd <= 1'b0;
      case (state_reg)
        ias_pkg::IAS_ACC: begin
          case (cyc_reg)
            // status word with master enable first
            `IAS_ACC_PSW: begin
              mem_wr    <= 1'b1;
              mem_addr  <= spw_reg;
              mem_wdata <= {psws_reg[6:1], psws_reg[0], mefs_reg};
            end
            `IAS_ACC_PCH: begin
              mem_wr    <= 1'b1;
              mem_addr  <= spw_reg - 16'h0001;
              mem_wdata <= pcs_reg[15:8];
            end
            // pc low lands at final sp plus one
            `IAS_ACC_PCL: begin
              mem_wr    <= 1'b1;
              mem_addr  <= spw_reg - 16'h0002;
              mem_wdata <= pcs_reg[7:0];
            end
            `IAS_ACC_VLO: begin
              mem_rd   <= 1'b1;
              mem_addr <= `IAS_VEC_BASE + {11'h000, src_reg, 1'b0};
            end
            `IAS_ACC_VHI: begin
              mem_rd   <= 1'b1;
              mem_addr <= `IAS_VEC_BASE + {11'h000, src_reg, 1'b1};
            end
            default: ;
          endcase
        end
        ias_pkg::IAS_RET: begin
          // pop pc low, pc high, status
          case (cyc_reg)
            `IAS_RET_RLO: begin
              mem_rd   <= 1'b1;
              mem_addr <= spw_reg + 16'h0001;
            end
            `IAS_RET_RHI: begin
              mem_rd   <= 1'b1;
              mem_addr <= spw_reg + 16'h0002;
            end
            `IAS_RET_GLO: begin
              mem_rd   <= 1'b1;
              mem_addr <= spw_reg + `IAS_SP_STEP;
            end
            default: ;
          endcase
        end
        default: ;
      endcase
    end
  end

  // register loads towards the cpu
  always_ff @(posedge clk) begin
    if (rst) begin
      pc_load   <= 1'b0;
      pc_value  <= 16'h0000;
      psw_load  <= 1'b0;
      psw_value <= 7'h00;
      sp_load   <= 1'b0;
      sp_value  <= 16'h0000;
    end else begin
      pc_load  <= 1'b0;
      psw_load <= 1'b0;
      sp_load  <= 1'b0;
      if (state_reg == ias_pkg::IAS_ACC &&
          cyc_reg == `IAS_ACC_LAST) begin
        // jump to entry, sp down by three
        pc_load  <= 1'b1;
        pc_value <= pcs_reg;
        sp_load  <= 1'b1;
        sp_value <= spw_reg - `IAS_SP_STEP;
      end else if (ret_end) begin
        // restore pc, status and sp plus three
        pc_load   <= 1'b1;
        pc_value  <= pcs_reg;
        psw_load  <= 1'b1;
        psw_value <= mem_rdata[7:1];
        sp_load   <= 1'b1;
        sp_value  <= sp_rest;
      end
    end
  end

  // non-maskable service tracking
  always_ff @(posedge clk) begin
    if (rst) begin
      nm_act_reg <= 1'b0;
    end else if (accept && pick < 4'(`IAS_FIRST_MASK)) begin
      nm_act_reg <= 1'b1;
    end else if (ret_go & return_nonmaskable) begin
      nm_act_reg <= 1'b0;
    end
  end

  // hold the cpu and pass fetched opcodes on
  always_ff @(posedge clk) begin
    if (rst) begin
      cpu_hold     <= 1'b0;
      opcode_out   <= 8'h00;
      opcode_valid <= 1'b0;
      trap_reset   <= 1'b0;
    end else begin
      cpu_hold     <= accept | ret_go |
                      (~idle & ~ret_end &
                       ~(state_reg == ias_pkg::IAS_ACC &&
                         cyc_reg == `IAS_ACC_LAST));
      // data area fetches never reach the decoder
      opcode_valid <= fetch_valid & ~in_data;
      opcode_out   <= eff_op;
      trap_reset   <= fault_rst;
    end
  end

endmodule

// file: tb/ias_checker.sv
// port assertions for the interrupt acceptance sequencer
`timescale 1ns/1ns
`include "ias_cfg.svh"
module ias_checker (
  input wire logic        clk,
  input wire logic        rst,
  input wire logic        avs_read,
  input wire logic        avs_waitrequest,
  input wire logic        bad_opcode,
  input wire logic        fetch_valid,
  input wire logic [15:0] fetch_addr,
  input wire logic [7:0]  opcode_out,
  input wire logic        opcode_valid,
  input wire logic        cpu_hold,
  input wire logic        pc_load,
  input wire logic        psw_load,
  input wire logic        sp_load,
  input wire logic [15:0] sp_value,
  input wire logic        trap_reset,
  input wire logic        mem_wr,
  input wire logic        mem_rd,
  input wire logic [15:0] mem_addr
);
  logic [15:0] last_wr_reg;  // address of the newest stack push
  logic [15:0] last_rd_reg;  // address of the newest memory read
  // one core clock, one reset for every assertion
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  // remember addresses so stack pointer results can be tied to them
  always_ff @(posedge clk) begin
    if (mem_wr) last_wr_reg <= mem_addr;
    if (mem_rd) last_rd_reg <= mem_addr;
  end
  // three pushes, each one byte below the one before
  sequence push_three;
    mem_wr ##1 (mem_wr && mem_addr == $past(mem_addr) - 16'h0001)
      ##1 (mem_wr && mem_addr == $past(mem_addr) - 16'h0001);
  endsequence
  // vector low byte from the table, high byte just above it
  sequence vec_fetch;
    (mem_rd && mem_addr >= `IAS_VEC_BASE)
      ##1 (mem_rd && mem_addr == $past(mem_addr) + 16'h0001);
  endsequence
  a_push_order: assert property (
    $rose(mem_wr) |-> push_three ##1 vec_fetch)
    else $error("context push or vector read out of order");
  a_load_time: assert property (
    $rose(mem_wr) |-> ##[7:8] (pc_load && sp_load))
    else $error("vector load not at end of acceptance");
  a_hold_span: assert property (
    $rose(mem_wr) |-> cpu_hold [*7])
    else $error("cpu hold dropped during acceptance");
  a_acc_sp_low: assert property (
    (sp_load && !psw_load) |-> sp_value == last_wr_reg - 16'h0001)
    else $error("stack pointer not below saved pc low byte");
  a_ret_loads: assert property (
    psw_load |-> (pc_load && sp_load && sp_value == last_rd_reg))
    else $error("return did not restore pc, status and sp");
  a_bus_wait: assert property (
    $rose(avs_read) |-> avs_waitrequest ##1 !avs_waitrequest
      ##1 avs_waitrequest)
    else $error("bus read answer not after one wait state");
  a_miss_ff: assert property (
    (fetch_valid && fetch_addr > `IAS_DATA_TOP && fetch_addr < `IAS_ROM_BOT)
      |=> (opcode_valid && opcode_out == `IAS_SWI_OPCODE))
    else $error("missing address fetch did not give trap opcode");
  a_data_trap: assert property (
    (fetch_valid && fetch_addr <= `IAS_DATA_TOP) |=> !opcode_valid)
    else $error("data area fetch passed as an opcode");
  a_undef_now: assert property (
    (bad_opcode && !cpu_hold) |-> ##[1:4] $rose(mem_wr))
    else $error("bad opcode not accepted at once");
  a_fault_now: assert property (
    (fetch_valid && fetch_addr <= `IAS_DATA_TOP && !cpu_hold)
      |-> ##[1:5] ($rose(mem_wr) || trap_reset))
    else $error("fetch fault not handled at once");
endmodule

bind ias_sequencer ias_checker u_ias_checker (
  .clk(clk), .rst(rst), .avs_read(avs_read),
  .avs_waitrequest(avs_waitrequest), .bad_opcode(bad_opcode),
  .fetch_valid(fetch_valid), .fetch_addr(fetch_addr),
  .opcode_out(opcode_out), .opcode_valid(opcode_valid),
  .cpu_hold(cpu_hold), .pc_load(pc_load), .psw_load(psw_load),
  .sp_load(sp_load), .sp_value(sp_value), .trap_reset(trap_reset),
  .mem_wr(mem_wr), .mem_rd(mem_rd), .mem_addr(mem_addr));

// file: tb/ias_stack_mem.sv
// stack and vector table memory on the sequencer's far side
`timescale 1ns/1ns
module ias_stack_mem (
  input  wire logic        clk,
  input  wire logic        mem_wr,
  input  wire logic        mem_rd,
  input  wire logic [15:0] mem_addr,
  input  wire logic [7:0]  mem_wdata,
  output logic      [7:0]  mem_rdata
);
  logic [7:0] mem [0:65535];  // whole address space, byte wide
  logic       rd_reg;         // a read answer stands this cycle
  logic [7:0] q_reg;          // last byte read out
  initial begin
    for (int s = 0; s < 16; s++) begin
      mem[16'hFFE0 + 2 * s] = {4'h0, s[3:0]};
      mem[16'hFFE1 + 2 * s] = 8'hA0;
    end
  end
  // writes land at once, reads answer one cycle later
  always @(posedge clk) begin
    if (mem_wr) mem[mem_addr] <= mem_wdata;
    rd_reg <= mem_rd;
    if (mem_rd) q_reg <= mem[mem_addr];
  end
  // outside an answer the bus shows the inverse, so stale data never match
  assign mem_rdata = rd_reg ? q_reg : ~q_reg;
endmodule

// file: tb/testbench.sv
// self-checking bench for the interrupt acceptance sequencer
`timescale 1ns/1ns
`include "ias_cfg.svh"
`define CHK(got, exp) begin num_checks++; if ((got) !== (exp)) begin \
  failures++; $display("mismatch t=%0t got %h exp %h", $time, got, exp); \
  end end
module testbench;
  logic        clk, rst, avs_read, avs_write, avs_waitrequest;
  logic [3:0]  avs_address, avs_byteenable;
  logic [31:0] avs_writedata, avs_readdata, rd;
  logic        insn_last, bad_opcode, return_maskable, return_nonmaskable;
  logic        fetch_valid, opcode_valid, cpu_hold, pc_load, psw_load;
  logic        sp_load, trap_reset, mem_wr, mem_rd;
  logic [15:0] pc_in, sp_in, fetch_addr, pc_value, sp_value, mem_addr;
  logic [15:0] exp_sp;
  logic [6:0]  psw_in, psw_value;
  logic [7:0]  fetch_data, opcode_out, mem_wdata, mem_rdata;
  logic [15:4] irq_req;
  int          failures, num_checks;
  ias_sequencer u_ias_sequencer (
    .clk(clk), .rst(rst), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .insn_last(insn_last),
    .pc_in(pc_in), .psw_in(psw_in), .sp_in(sp_in),
    .bad_opcode(bad_opcode), .return_maskable(return_maskable),
    .return_nonmaskable(return_nonmaskable), .fetch_valid(fetch_valid),
    .fetch_addr(fetch_addr), .fetch_data(fetch_data),
    .opcode_out(opcode_out), .opcode_valid(opcode_valid),
    .cpu_hold(cpu_hold), .pc_load(pc_load), .pc_value(pc_value),
    .psw_load(psw_load), .psw_value(psw_value), .sp_load(sp_load),
    .sp_value(sp_value), .trap_reset(trap_reset), .mem_wr(mem_wr),
    .mem_rd(mem_rd), .mem_addr(mem_addr), .mem_wdata(mem_wdata),
    .mem_rdata(mem_rdata), .irq_req(irq_req));
  ias_stack_mem u_ias_stack_mem (
    .clk(clk), .mem_wr(mem_wr), .mem_rd(mem_rd), .mem_addr(mem_addr),
    .mem_wdata(mem_wdata), .mem_rdata(mem_rdata));
  // free running core clock
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  // verdict and end of run
  task automatic close_out();
    $display("failures=%0d num_checks=%0d", failures, num_checks);
    if (failures == 0 && num_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  // one bus transfer; read data land in rd
  task automatic av(input logic wr, input logic [3:0] a,
                    input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= wr;
    avs_read <= !wr;
    do begin
      @(posedge clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 20);
    rd = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    if (n >= 20) begin
      failures++;
      close_out();
    end
  endtask
  // wait for a design strobe, bounded: 0 pc load, 1 read, 2 trap reset
  task automatic wait_on(input int k, input int lim);
    int n;
    n = 0;
    forever begin
      @(posedge clk);
      if ((k == 0 ? pc_load : k == 1 ? mem_rd : trap_reset) === 1'b1) break;
      n++;
      if (n >= lim) begin
        failures++;
        close_out();
      end
    end
  endtask
  // entry address the vector table holds for a source
  function automatic logic [15:0] vec(input logic [3:0] s);
    return {8'hA0, 4'h0, s};
  endfunction
  // one pulse on the peripheral request lines
  task automatic irq(input logic [15:0] m);
    @(posedge clk);
    irq_req <= m[15:4];
    @(posedge clk);
    irq_req <= 12'h000;
  endtask
  // opcode fetch; valid flag and opcode land in rd
  task automatic fetch(input logic [15:0] a, input logic [7:0] d);
    @(posedge clk);
    fetch_valid <= 1'b1;
    fetch_addr <= a;
    fetch_data <= d;
    @(posedge clk);
    fetch_valid <= 1'b0;
    @(posedge clk);
    rd = {23'h0, opcode_valid, opcode_out};
  endtask
  // acceptance of source s with master enable m saved in the frame
  task automatic acc(input logic [3:0] s, input logic m, input int lim);
    wait_on(0, lim);
    `CHK(pc_value, vec(s))
    `CHK(sp_value, exp_sp - `IAS_SP_STEP)
    `CHK(u_ias_stack_mem.mem[exp_sp], {psw_in, m})
    `CHK(u_ias_stack_mem.mem[exp_sp - 16'h0001], pc_in[15:8])
    `CHK(u_ias_stack_mem.mem[exp_sp - 16'h0002], pc_in[7:0])
    exp_sp = exp_sp - `IAS_SP_STEP;
    sp_in <= exp_sp;
    av(1'b0, `IAS_OFF_STAT, 32'h0);
    `CHK(rd[3:0], s)
    `CHK(rd[5:4], {1'b0, s < `IAS_FIRST_MASK})
    av(1'b0, `IAS_OFF_ENABLE, 32'h0);
    `CHK(rd[0], 1'b0)
  endtask
  // return instruction; cpu moves its sp once the pops begin
  task automatic ret(input logic nm);
    @(posedge clk);
    return_maskable <= !nm;
    return_nonmaskable <= nm;
    @(posedge clk);
    return_maskable <= 1'b0;
    return_nonmaskable <= 1'b0;
    wait_on(1, 10);
    sp_in <= exp_sp + `IAS_SP_STEP;
    wait_on(0, 12);
    `CHK(pc_value, pc_in)
    `CHK(psw_value, psw_in)
    `CHK(sp_value, exp_sp + `IAS_SP_STEP)
    exp_sp = exp_sp + `IAS_SP_STEP;
  endtask
  // reset values and an unmapped offset
  task automatic t_reset();
    av(1'b0, `IAS_OFF_ENABLE, 32'h0);
    `CHK(rd[15:0], `IAS_ENABLE_RESET)
    av(1'b0, `IAS_OFF_CTRL, 32'h0);
    `CHK(rd[1:0], `IAS_CTRL_RESET)
    av(1'b0, 4'h2, 32'h0);
    `CHK(rd, 32'h0)
  endtask
  // maskable priority, masking while served, chaining after return
  task automatic t_mask();
    av(1'b1, `IAS_OFF_ENABLE, 32'h0000_0231);
    irq(16'h0220);
    repeat (30) @(posedge clk);
    `CHK(cpu_hold, 1'b0)
    av(1'b0, `IAS_OFF_PEND, 32'h0);
    `CHK(rd[15:0], 16'h0220)
    insn_last <= 1'b1;
    acc(4'h5, 1'b1, 48);
    av(1'b0, `IAS_OFF_PEND, 32'h0);
    `CHK(rd[15:0], 16'h0200)
    irq(16'h0010);
    repeat (20) @(posedge clk);
    `CHK(cpu_hold, 1'b0)
    ret(1'b0);
    acc(4'h4, 1'b1, 14);
    ret(1'b0);
    acc(4'h9, 1'b1, 14);
    // handler drops its own enable before opening nesting
    av(1'b1, `IAS_OFF_ENABLE, 32'h0000_0030);
    av(1'b1, `IAS_OFF_ENABLE, 32'h0000_0031);
    ret(1'b0);
    av(1'b0, `IAS_OFF_ENABLE, 32'h0);
    `CHK(rd[0], 1'b1)
  endtask
  // software trap, nested fetch fault and bad opcode, reset mode
  task automatic t_nm();
    fetch(16'h5000, 8'h00);
    `CHK(rd[8:0], {1'b1, `IAS_SWI_OPCODE})
    acc(`IAS_SRC_SW, 1'b1, 14);
    fetch(16'h0100, 8'h5A);
    `CHK(rd[8], 1'b0)
    acc(`IAS_SRC_FAULT, 1'b0, 14);
    @(posedge clk);
    bad_opcode <= 1'b1;
    @(posedge clk);
    bad_opcode <= 1'b0;
    acc(`IAS_SRC_UNDEF, 1'b0, 14);
    ret(1'b1);
    av(1'b0, `IAS_OFF_ENABLE, 32'h0);
    `CHK(rd[0], 1'b0)
    // fault handler patches its frame with a restart address
    pc_in <= 16'hC100;
    u_ias_stack_mem.mem[exp_sp + 16'h0001] <= 8'h00;
    u_ias_stack_mem.mem[exp_sp + 16'h0002] <= 8'hC1;
    ret(1'b1);
    av(1'b1, `IAS_OFF_CTRL, 32'h0000_0003);
    @(posedge clk);
    fetch_valid <= 1'b1;
    fetch_addr <= 16'h0200;
    @(posedge clk);
    fetch_valid <= 1'b0;
    wait_on(2, 6);
    `CHK(trap_reset, 1'b1)
  endtask
  // main sequence: every input set at time zero, reset for 16 cycles
  initial begin
    {rst, avs_read, avs_write, insn_last, bad_opcode} = 5'h10;
    {return_maskable, return_nonmaskable, fetch_valid} = 3'h0;
    {failures, num_checks} = 0;
    avs_address = 4'h0;
    avs_writedata = 32'h0;
    avs_byteenable = 4'hF;
    pc_in = 16'h1234;
    psw_in = 7'h2A;
    exp_sp = 16'h03F0;
    sp_in = exp_sp;
    fetch_addr = 16'hC000;
    fetch_data = 8'h00;
    irq_req = 12'h000;
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    t_reset();
    t_mask();
    t_nm();
    close_out();
  end
endmodule
